// [hw/opdec_pkg.sv]
// Package for the opcode decoder: opcode patterns, extension codes,
// operation enumeration and instruction length figures.
// Assumes a byte-serial instruction stream on one clock.
package opdec_pkg;

  // Full opcode bytes
  localparam logic [7:0] OP_ASCII_SUB_ADJ = 8'h3F;
  localparam logic [7:0] OP_DECIMAL_SUB_ADJ = 8'h2F;
  localparam logic [7:0] OP_ASCII_PROD_ADJ = 8'hD4;
  localparam logic [7:0] OP_ASCII_QUOT_ADJ = 8'hD5;
  localparam logic [7:0] OP_ADJ_BASE = 8'h0A;
  localparam logic [7:0] OP_BYTE_TO_WORD = 8'h98;
  localparam logic [7:0] OP_WORD_TO_DOUBLE = 8'h99;
  localparam logic [7:0] OP_EXIT_NEAR = 8'hC3;
  localparam logic [7:0] OP_EXIT_NEAR_IMM = 8'hC2;
  localparam logic [7:0] OP_EXIT_FAR = 8'hCB;
  localparam logic [7:0] OP_CALL_NEAR = 8'hE8;
  localparam logic [7:0] OP_CALL_FAR = 8'h9A;
  localparam logic [7:0] OP_BRANCH_NEAR = 8'hE9;
  localparam logic [7:0] OP_BRANCH_SHORT = 8'hEB;
  localparam logic [7:0] OP_BRANCH_FAR = 8'hEA;
  localparam logic [7:0] OP_GRP_FF = 8'hFF;

  // Opcodes with the size bit (bit 0) cleared; compare bits 7..1
  localparam logic [6:0] OP7_GRP_F6 = 7'h7B;
  localparam logic [6:0] OP7_TEST_RM = 7'h42;
  localparam logic [6:0] OP7_TEST_ACC = 7'h54;
  localparam logic [6:0] OP7_STR_COPY = 7'h52;
  localparam logic [6:0] OP7_STR_CMP = 7'h53;
  localparam logic [6:0] OP7_STR_SCAN = 7'h57;
  localparam logic [6:0] OP7_STR_LOAD = 7'h56;
  localparam logic [6:0] OP7_STR_STORE = 7'h55;
  localparam logic [6:0] OP7_LOOP_PREFIX = 7'h79;

  // Opcodes with direction and size bits cleared; compare bits 7..2
  localparam logic [5:0] OP6_SHIFT = 6'h34;
  localparam logic [5:0] OP6_OR_RM = 6'h02;
  localparam logic [5:0] OP6_XOR_RM = 6'h0C;

  // Extension field codes (second byte bits 5..3)
  localparam logic [2:0] EXT_0 = 3'h0;
  localparam logic [2:0] EXT_1 = 3'h1;
  localparam logic [2:0] EXT_2 = 3'h2;
  localparam logic [2:0] EXT_3 = 3'h3;
  localparam logic [2:0] EXT_4 = 3'h4;
  localparam logic [2:0] EXT_5 = 3'h5;
  localparam logic [2:0] EXT_6 = 3'h6;
  localparam logic [2:0] EXT_7 = 3'h7;

  // Addressing form meaning register operand
  localparam logic [1:0] MOD_REG = 2'h3;

  // Byte counts of trailing operand bytes
  localparam logic [2:0] LEN_0 = 3'h0;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_4 = 3'h4;

  // Decoded operations
  typedef enum logic [5:0] {
    OPD_NONE, OPD_ASCII_SUB_ADJUST, OPD_DECIMAL_SUB_ADJUST,
    OPD_PRODUCT_OP, OPD_SIGNED_PRODUCT, OPD_QUOTIENT_OP, OPD_SIGNED_QUOTIENT,
    OPD_MASK_COMPARE_IMM, OPD_INVERT, OPD_ASCII_PRODUCT_ADJUST,
    OPD_ASCII_QUOTIENT_ADJUST, OPD_BYTE_TO_WORD_SIGN_EXTEND,
    OPD_WORD_TO_DOUBLE_SIGN_EXTEND, OPD_ROTATE_LEFT, OPD_ROTATE_RIGHT,
    OPD_CARRY_ROTATE_LEFT, OPD_CARRY_ROTATE_RIGHT, OPD_LEFT_SHIFT,
    OPD_LOGICAL_RIGHT_SHIFT, OPD_ARITH_RIGHT_SHIFT, OPD_OR_RM, OPD_XOR_RM,
    OPD_MASK_COMPARE_RM, OPD_MASK_COMPARE_ACC, OPD_STRING_COPY,
    OPD_STRING_COMPARE, OPD_STRING_SCAN, OPD_STRING_LOAD, OPD_STRING_STORE,
    OPD_SUBROUTINE_EXIT, OPD_SUBROUTINE_EXIT_FAR, OPD_SUBROUTINE_EXIT_IMM,
    OPD_CALL_NEAR, OPD_CALL_FAR, OPD_CALL_INDIRECT_NEAR, OPD_CALL_INDIRECT_FAR,
    OPD_BRANCH_NEAR, OPD_BRANCH_SHORT, OPD_BRANCH_FAR,
    OPD_BRANCH_INDIRECT_NEAR, OPD_BRANCH_INDIRECT_FAR
  } opdec_op_t;

  // Byte-collection states
  typedef enum logic [1:0] {
    OPDEC_ST_OPCODE, OPDEC_ST_MODRM, OPDEC_ST_TRAIL
  } opdec_state_t;

endpackage : opdec_pkg

// [hw/opdec_top.sv]
// Opcode decoder for the arithmetic tail, logic, string and branch groups.
// Takes one instruction byte per valid cycle from the fetch stream on
// i_sys_clk; decodes the opcode, the mode byte and trailing byte counts.
`timescale 1ns/10ps

module opdec_top (
  input wire logic i_sys_clk, // 40 MHz core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_byte_valid, // Instruction byte present
  input wire logic [7:0] i_byte, // Instruction byte
  output logic o_done, // One-cycle pulse: decode complete
  output opdec_pkg::opdec_op_t o_op, // Decoded operation
  output logic o_word, // Word-sized operation
  output logic o_count_from_reg, // Shift count from count register
  output logic o_repeat, // Repeat prefix applies
  output logic o_repeat_zf, // Prefix low bit for zero flag test
  output logic o_operand_is_reg, // Operand field names a register
  output logic [1:0] o_mod, // Addressing form field
  output logic [2:0] o_reg, // Register/extension field
  output logic [2:0] o_rm, // Operand field
  output logic [2:0] o_trail_len, // Trailing immediate/disp bytes
  output logic o_illegal // Byte not in this decoder's map
);

  opdec_pkg::opdec_state_t state; // Collection state
  logic [7:0] opcode; // Held opcode byte
  logic pend_rep; // Prefix seen, awaiting primitive
  logic pend_z; // Prefix low bit
  logic [2:0] trail_left; // Trailing bytes still to absorb
  logic [2:0] next_trail; // Trailing count from mode byte
  opdec_pkg::opdec_op_t next_op; // Op from first byte
  logic need_modrm; // Opcode takes a mode byte
  logic first_ill; // First byte unknown
  logic [2:0] first_trail; // Trailing count for single-byte opcodes
  opdec_pkg::opdec_op_t modrm_op; // Op from mode byte
  logic modrm_ill; // Mode byte extension not mapped

  // First-byte decode
  always_comb begin
    next_op = opdec_pkg::OPD_NONE;
    need_modrm = 1'b0;
    first_ill = 1'b0;
    first_trail = opdec_pkg::LEN_0;
    if (i_byte == opdec_pkg::OP_ASCII_SUB_ADJ) begin
      next_op = opdec_pkg::OPD_ASCII_SUB_ADJUST;
    end else if (i_byte == opdec_pkg::OP_DECIMAL_SUB_ADJ) begin
      next_op = opdec_pkg::OPD_DECIMAL_SUB_ADJUST;
    end else if (i_byte == opdec_pkg::OP_ASCII_PROD_ADJ ||
                 i_byte == opdec_pkg::OP_ASCII_QUOT_ADJ) begin
      need_modrm = 1'b1; // Second byte checked as base
    end else if (i_byte == opdec_pkg::OP_BYTE_TO_WORD) begin
      next_op = opdec_pkg::OPD_BYTE_TO_WORD_SIGN_EXTEND;
    end else if (i_byte == opdec_pkg::OP_WORD_TO_DOUBLE) begin
      next_op = opdec_pkg::OPD_WORD_TO_DOUBLE_SIGN_EXTEND;
    end else if (i_byte == opdec_pkg::OP_EXIT_NEAR) begin
      next_op = opdec_pkg::OPD_SUBROUTINE_EXIT;
    end else if (i_byte == opdec_pkg::OP_EXIT_FAR) begin
      next_op = opdec_pkg::OPD_SUBROUTINE_EXIT_FAR;
    end else if (i_byte == opdec_pkg::OP_EXIT_NEAR_IMM) begin
      next_op = opdec_pkg::OPD_SUBROUTINE_EXIT_IMM;
      first_trail = opdec_pkg::LEN_2;
    end else if (i_byte == opdec_pkg::OP_CALL_NEAR) begin
      next_op = opdec_pkg::OPD_CALL_NEAR;
      first_trail = opdec_pkg::LEN_2;
    end else if (i_byte == opdec_pkg::OP_CALL_FAR) begin
      next_op = opdec_pkg::OPD_CALL_FAR;
      first_trail = opdec_pkg::LEN_4;
    end else if (i_byte == opdec_pkg::OP_BRANCH_NEAR) begin
      next_op = opdec_pkg::OPD_BRANCH_NEAR;
      first_trail = opdec_pkg::LEN_2;
    end else if (i_byte == opdec_pkg::OP_BRANCH_SHORT) begin
      next_op = opdec_pkg::OPD_BRANCH_SHORT;
      first_trail = opdec_pkg::LEN_1;
    end else if (i_byte == opdec_pkg::OP_BRANCH_FAR) begin
      next_op = opdec_pkg::OPD_BRANCH_FAR;
      first_trail = opdec_pkg::LEN_4;
    end else if (i_byte == opdec_pkg::OP_GRP_FF) begin
      need_modrm = 1'b1; // Indirect call/jump group
    end else if (i_byte[7:1] == opdec_pkg::OP7_GRP_F6 ||
                 i_byte[7:1] == opdec_pkg::OP7_TEST_RM ||
                 i_byte[7:2] == opdec_pkg::OP6_SHIFT ||
                 i_byte[7:2] == opdec_pkg::OP6_OR_RM ||
                 i_byte[7:2] == opdec_pkg::OP6_XOR_RM) begin
      need_modrm = 1'b1;
    end else if (i_byte[7:1] == opdec_pkg::OP7_TEST_ACC) begin
      next_op = opdec_pkg::OPD_MASK_COMPARE_ACC;
      first_trail = i_byte[0] ? opdec_pkg::LEN_2 : opdec_pkg::LEN_1;
    end else if (i_byte[7:1] == opdec_pkg::OP7_STR_COPY) begin
      next_op = opdec_pkg::OPD_STRING_COPY;
    end else if (i_byte[7:1] == opdec_pkg::OP7_STR_CMP) begin
      next_op = opdec_pkg::OPD_STRING_COMPARE;
    end else if (i_byte[7:1] == opdec_pkg::OP7_STR_SCAN) begin
      next_op = opdec_pkg::OPD_STRING_SCAN;
    end else if (i_byte[7:1] == opdec_pkg::OP7_STR_LOAD) begin
      next_op = opdec_pkg::OPD_STRING_LOAD;
    end else if (i_byte[7:1] == opdec_pkg::OP7_STR_STORE) begin
      next_op = opdec_pkg::OPD_STRING_STORE;
    end else if (i_byte[7:1] != opdec_pkg::OP7_LOOP_PREFIX) begin
      first_ill = 1'b1; // Outside this decoder's map
    end
  end

  // Mode-byte decode, using the held opcode
  always_comb begin
    modrm_op = opdec_pkg::OPD_NONE;
    modrm_ill = 1'b0;
    next_trail = opdec_pkg::LEN_0;
    if (opcode == opdec_pkg::OP_ASCII_PROD_ADJ) begin
      modrm_op = opdec_pkg::OPD_ASCII_PRODUCT_ADJUST;
      modrm_ill = (i_byte != opdec_pkg::OP_ADJ_BASE);
    end else if (opcode == opdec_pkg::OP_ASCII_QUOT_ADJ) begin
      modrm_op = opdec_pkg::OPD_ASCII_QUOTIENT_ADJUST;
      modrm_ill = (i_byte != opdec_pkg::OP_ADJ_BASE);
    end else if (opcode == opdec_pkg::OP_GRP_FF) begin
      unique case (i_byte[5:3])
        opdec_pkg::EXT_2: modrm_op = opdec_pkg::OPD_CALL_INDIRECT_NEAR;
        opdec_pkg::EXT_3: modrm_op = opdec_pkg::OPD_CALL_INDIRECT_FAR;
        opdec_pkg::EXT_4: modrm_op = opdec_pkg::OPD_BRANCH_INDIRECT_NEAR;
        opdec_pkg::EXT_5: modrm_op = opdec_pkg::OPD_BRANCH_INDIRECT_FAR;
        default: modrm_ill = 1'b1; // Other extensions belong elsewhere
      endcase
    end else if (opcode[7:1] == opdec_pkg::OP7_GRP_F6) begin
      unique case (i_byte[5:3])
        opdec_pkg::EXT_0: begin
          modrm_op = opdec_pkg::OPD_MASK_COMPARE_IMM;
          next_trail = opcode[0] ? opdec_pkg::LEN_2 : opdec_pkg::LEN_1;
        end
        opdec_pkg::EXT_2: modrm_op = opdec_pkg::OPD_INVERT;
        opdec_pkg::EXT_4: modrm_op = opdec_pkg::OPD_PRODUCT_OP;
        opdec_pkg::EXT_5: modrm_op = opdec_pkg::OPD_SIGNED_PRODUCT;
        opdec_pkg::EXT_6: modrm_op = opdec_pkg::OPD_QUOTIENT_OP;
        opdec_pkg::EXT_7: modrm_op = opdec_pkg::OPD_SIGNED_QUOTIENT;
        default: modrm_ill = 1'b1; // Negate and reserved not covered
      endcase
    end else if (opcode[7:2] == opdec_pkg::OP6_SHIFT) begin
      unique case (i_byte[5:3])
        opdec_pkg::EXT_0: modrm_op = opdec_pkg::OPD_ROTATE_LEFT;
        opdec_pkg::EXT_1: modrm_op = opdec_pkg::OPD_ROTATE_RIGHT;
        opdec_pkg::EXT_2: modrm_op = opdec_pkg::OPD_CARRY_ROTATE_LEFT;
        opdec_pkg::EXT_3: modrm_op = opdec_pkg::OPD_CARRY_ROTATE_RIGHT;
        opdec_pkg::EXT_4: modrm_op = opdec_pkg::OPD_LEFT_SHIFT;
        opdec_pkg::EXT_5: modrm_op = opdec_pkg::OPD_LOGICAL_RIGHT_SHIFT;
        opdec_pkg::EXT_7: modrm_op = opdec_pkg::OPD_ARITH_RIGHT_SHIFT;
        default: modrm_ill = 1'b1; // Extension 110 unmapped
      endcase
    end else if (opcode[7:2] == opdec_pkg::OP6_OR_RM) begin
      modrm_op = opdec_pkg::OPD_OR_RM;
    end else if (opcode[7:2] == opdec_pkg::OP6_XOR_RM) begin
      modrm_op = opdec_pkg::OPD_XOR_RM;
    end else begin
      modrm_op = opdec_pkg::OPD_MASK_COMPARE_RM;
    end
  end

  // Byte collection sequence
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= opdec_pkg::OPDEC_ST_OPCODE;
      opcode <= 8'h00;
      trail_left <= opdec_pkg::LEN_0;
    end else if (i_byte_valid) begin
      unique case (state)
        opdec_pkg::OPDEC_ST_OPCODE: begin
          opcode <= i_byte;
          trail_left <= first_trail;
          if (need_modrm) begin
            state <= opdec_pkg::OPDEC_ST_MODRM;
          end else if (!first_ill && first_trail != opdec_pkg::LEN_0) begin
            state <= opdec_pkg::OPDEC_ST_TRAIL; // Absorb immediates
          end
        end
        opdec_pkg::OPDEC_ST_MODRM: begin
          trail_left <= next_trail;
          if (!modrm_ill && next_trail != opdec_pkg::LEN_0) begin
            state <= opdec_pkg::OPDEC_ST_TRAIL;
          end else begin
            state <= opdec_pkg::OPDEC_ST_OPCODE;
          end
        end
        opdec_pkg::OPDEC_ST_TRAIL: begin
          trail_left <= trail_left - opdec_pkg::LEN_1;
          if (trail_left == opdec_pkg::LEN_1) begin
            state <= opdec_pkg::OPDEC_ST_OPCODE;
          end
        end
      endcase
    end
  end

  // Repeat prefix latch, consumed by the next opcode
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_rep <= 1'b0;
      pend_z <= 1'b0;
    end else if (i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE) begin
      pend_rep <= (i_byte[7:1] == opdec_pkg::OP7_LOOP_PREFIX);
      // Only a prefix arms the zero-flag bit; other opcodes clear it
      pend_z <= i_byte[0] & (i_byte[7:1] == opdec_pkg::OP7_LOOP_PREFIX);
    end
  end

  // Result registers; done pulses once the op is known
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
      o_op <= opdec_pkg::OPD_NONE;
      o_word <= 1'b0;
      o_count_from_reg <= 1'b0;
      o_repeat <= 1'b0;
      o_repeat_zf <= 1'b0;
      o_operand_is_reg <= 1'b0;
      o_mod <= 2'h0;
      o_reg <= 3'h0;
      o_rm <= 3'h0;
      o_trail_len <= 3'h0;
      o_illegal <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      if (i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
          !need_modrm && i_byte[7:1] != opdec_pkg::OP7_LOOP_PREFIX) begin
        o_done <= ~first_ill;
        o_illegal <= first_ill;
        o_op <= next_op;
        o_word <= i_byte[0];
        o_count_from_reg <= 1'b0;
        o_repeat <= pend_rep;
        o_repeat_zf <= pend_z;
        o_operand_is_reg <= 1'b0;
        o_mod <= 2'h0;
        o_reg <= 3'h0;
        o_rm <= 3'h0;
        o_trail_len <= first_trail;
      end else if (i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM) begin
        o_done <= ~modrm_ill;
        o_illegal <= modrm_ill;
        o_op <= modrm_op;
        o_word <= opcode[0];
        o_count_from_reg <= (opcode[7:2] == opdec_pkg::OP6_SHIFT) & opcode[1];
        o_repeat <= 1'b0;
        o_repeat_zf <= 1'b0;
        o_operand_is_reg <= (i_byte[7:6] == opdec_pkg::MOD_REG);
        o_mod <= i_byte[7:6];
        o_reg <= i_byte[5:3];
        o_rm <= i_byte[2:0];
        o_trail_len <= next_trail;
      end
    end
  end

  // Checks
  a_sub_adjust: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte == opdec_pkg::OP_ASCII_SUB_ADJ |=>
    o_done && o_op == opdec_pkg::OPD_ASCII_SUB_ADJUST && o_trail_len == opdec_pkg::LEN_0)
    else $error("ascii subtract adjust misdecoded");
  a_dec_adjust: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte == opdec_pkg::OP_DECIMAL_SUB_ADJ |=>
    o_done && o_op == opdec_pkg::OPD_DECIMAL_SUB_ADJUST)
    else $error("decimal subtract adjust misdecoded");
  a_product_signed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode[7:1] == opdec_pkg::OP7_GRP_F6 && i_byte[5:3] == opdec_pkg::EXT_5 |=>
    o_op == opdec_pkg::OPD_SIGNED_PRODUCT)
    else $error("signed multiply misdecoded");
  a_div_unsigned: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode[7:1] == opdec_pkg::OP7_GRP_F6 && i_byte[5:3] == opdec_pkg::EXT_6 |=>
    o_op == opdec_pkg::OPD_QUOTIENT_OP)
    else $error("unsigned divide misdecoded");
  a_test_imm_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_done && o_op == opdec_pkg::OPD_MASK_COMPARE_IMM |->
    o_trail_len == (o_word ? opdec_pkg::LEN_2 : opdec_pkg::LEN_1))
    else $error("test immediate length wrong");
  // A bad base byte after the multiply adjust must not decode
  a_adjust_pair: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode == opdec_pkg::OP_ASCII_PROD_ADJ && i_byte != opdec_pkg::OP_ADJ_BASE |=>
    o_illegal && !o_done)
    else $error("multiply adjust base byte not checked");
  a_quot_adjust: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode == opdec_pkg::OP_ASCII_QUOT_ADJ && i_byte == opdec_pkg::OP_ADJ_BASE |=>
    o_done && o_op == opdec_pkg::OPD_ASCII_QUOTIENT_ADJUST)
    else $error("divide adjust misdecoded");
  a_sign_extend: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte == opdec_pkg::OP_WORD_TO_DOUBLE |=>
    o_done && o_op == opdec_pkg::OPD_WORD_TO_DOUBLE_SIGN_EXTEND)
    else $error("word sign extend misdecoded");
  a_arith_shift: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode[7:2] == opdec_pkg::OP6_SHIFT && i_byte[5:3] == opdec_pkg::EXT_7 |=>
    o_done && o_op == opdec_pkg::OPD_ARITH_RIGHT_SHIFT)
    else $error("arithmetic right shift misdecoded");
  a_xor_form: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode[7:2] == opdec_pkg::OP6_XOR_RM |=>
    o_done && o_op == opdec_pkg::OPD_XOR_RM && o_reg == $past(i_byte[5:3]))
    else $error("exclusive or form misdecoded");
  a_test_acc_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte[7:1] == opdec_pkg::OP7_TEST_ACC |=> o_op == opdec_pkg::OPD_MASK_COMPARE_ACC &&
    o_trail_len == (o_word ? opdec_pkg::LEN_2 : opdec_pkg::LEN_1))
    else $error("accumulator test length wrong");
  a_shift_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_MODRM &&
    opcode[7:2] == opdec_pkg::OP6_SHIFT |=>
    o_count_from_reg == $past(opcode[1]))
    else $error("shift count source wrong");
  a_repeat_prefix: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte[7:1] == opdec_pkg::OP7_LOOP_PREFIX ##1
    i_byte_valid && i_byte[7:1] == opdec_pkg::OP7_STR_CMP |=>
    o_repeat && o_op == opdec_pkg::OPD_STRING_COMPARE)
    else $error("repeat prefix lost");
  a_exit_imm_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte == opdec_pkg::OP_EXIT_NEAR_IMM |=>
    o_trail_len == opdec_pkg::LEN_2 ##0 state == opdec_pkg::OPDEC_ST_TRAIL)
    else $error("return immediate length wrong");
  // Swallowed immediates never raise an answer
  a_trail_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_TRAIL |=> !o_done && !o_illegal)
    else $error("trailing byte answered");
  a_far_call_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte == opdec_pkg::OP_CALL_FAR |=>
    o_done && o_op == opdec_pkg::OPD_CALL_FAR && o_trail_len == opdec_pkg::LEN_4)
    else $error("far call length wrong");
  a_short_branch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_byte_valid && state == opdec_pkg::OPDEC_ST_OPCODE &&
    i_byte == opdec_pkg::OP_BRANCH_SHORT |=>
    o_op == opdec_pkg::OPD_BRANCH_SHORT && o_trail_len == opdec_pkg::LEN_1)
    else $error("short branch length wrong");
  a_reg_operand: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_done |-> o_operand_is_reg == (o_mod == opdec_pkg::MOD_REG))
    else $error("register operand flag wrong");

  c_far_call: cover property (@(posedge i_sys_clk) o_done && o_op == opdec_pkg::OPD_CALL_FAR);
  c_repeat_scan: cover property (@(posedge i_sys_clk) o_done && o_repeat &&
    o_op == opdec_pkg::OPD_STRING_SCAN);
  c_prod_adj: cover property (@(posedge i_sys_clk) o_op == opdec_pkg::OPD_ASCII_PRODUCT_ADJUST);
  c_illegal: cover property (@(posedge i_sys_clk) o_illegal);

endmodule : opdec_top

// [dv/test_opcode_decode_arith_logic_string_branch.sv]
// Self-checking bench for the opcode decoder: feeds byte streams, checks results.
// Assumes one 40 MHz clock, async active-low reset, no partner model.
`timescale 1ns/10ps

module test_opcode_decode_arith_logic_string_branch;
  logic i_sys_clk = 1'b0; // Core clock
  logic i_rst_n = 1'b0; // Reset, active low
  logic i_byte_valid = 1'b0; // Byte strobe
  logic [7:0] i_byte = 8'h00; // Instruction byte
  logic o_done, o_word, o_count_from_reg, o_repeat, o_repeat_zf;
  logic o_operand_is_reg, o_illegal;
  opdec_pkg::opdec_op_t o_op; // Decoded operation
  logic [1:0] o_mod;
  logic [2:0] o_reg, o_rm, o_trail_len;
  int num_errors = 0; // Mismatch count
  int compares = 0; // Comparison count
  // Shift group ops by extension; slot 6 is unmapped
  opdec_pkg::opdec_op_t sh_op[8] = '{opdec_pkg::OPD_ROTATE_LEFT, opdec_pkg::OPD_ROTATE_RIGHT,
    opdec_pkg::OPD_CARRY_ROTATE_LEFT, opdec_pkg::OPD_CARRY_ROTATE_RIGHT,
    opdec_pkg::OPD_LEFT_SHIFT, opdec_pkg::OPD_LOGICAL_RIGHT_SHIFT, opdec_pkg::OPD_NONE,
    opdec_pkg::OPD_ARITH_RIGHT_SHIFT};
  // Multiply, divide, mask compare and invert group extensions and ops
  logic [2:0] f6_ext[6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  opdec_pkg::opdec_op_t f6_op[6] = '{opdec_pkg::OPD_MASK_COMPARE_IMM, opdec_pkg::OPD_INVERT,
    opdec_pkg::OPD_PRODUCT_OP, opdec_pkg::OPD_SIGNED_PRODUCT, opdec_pkg::OPD_QUOTIENT_OP,
    opdec_pkg::OPD_SIGNED_QUOTIENT};
  // String primitives, size bit cleared
  logic [6:0] st_opc[5] = '{7'h52, 7'h53, 7'h57, 7'h56, 7'h55};
  opdec_pkg::opdec_op_t st_op[5] = '{opdec_pkg::OPD_STRING_COPY, opdec_pkg::OPD_STRING_COMPARE,
    opdec_pkg::OPD_STRING_SCAN, opdec_pkg::OPD_STRING_LOAD, opdec_pkg::OPD_STRING_STORE};
  // Opcodes with trailing bytes only, and their counts
  logic [7:0] br_opc[6] = '{8'he8, 8'h9a, 8'he9, 8'heb, 8'hea, 8'hc2};
  logic [2:0] br_len[6] = '{3'h2, 3'h4, 3'h2, 3'h1, 3'h4, 3'h2};
  opdec_pkg::opdec_op_t br_op[6] = '{opdec_pkg::OPD_CALL_NEAR, opdec_pkg::OPD_CALL_FAR,
    opdec_pkg::OPD_BRANCH_NEAR, opdec_pkg::OPD_BRANCH_SHORT, opdec_pkg::OPD_BRANCH_FAR,
    opdec_pkg::OPD_SUBROUTINE_EXIT_IMM};
  // Indirect forms of the FF group, extensions 2..5
  opdec_pkg::opdec_op_t ff_op[4] = '{opdec_pkg::OPD_CALL_INDIRECT_NEAR,
    opdec_pkg::OPD_CALL_INDIRECT_FAR, opdec_pkg::OPD_BRANCH_INDIRECT_NEAR,
    opdec_pkg::OPD_BRANCH_INDIRECT_FAR};
  // Single-byte opcodes
  logic [7:0] sb_opc[6] = '{8'h3f, 8'h2f, 8'h98, 8'h99, 8'hc3, 8'hcb};
  opdec_pkg::opdec_op_t sb_op[6] = '{opdec_pkg::OPD_ASCII_SUB_ADJUST,
    opdec_pkg::OPD_DECIMAL_SUB_ADJUST, opdec_pkg::OPD_BYTE_TO_WORD_SIGN_EXTEND,
    opdec_pkg::OPD_WORD_TO_DOUBLE_SIGN_EXTEND, opdec_pkg::OPD_SUBROUTINE_EXIT,
    opdec_pkg::OPD_SUBROUTINE_EXIT_FAR};

  opdec_top i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .o_done(o_done), .o_op(o_op), .o_word(o_word),
    .o_count_from_reg(o_count_from_reg), .o_repeat(o_repeat), .o_repeat_zf(o_repeat_zf),
    .o_operand_is_reg(o_operand_is_reg), .o_mod(o_mod), .o_reg(o_reg), .o_rm(o_rm),
    .o_trail_len(o_trail_len), .o_illegal(o_illegal));

  // 25 ns clock
  always #12.5 i_sys_clk = ~i_sys_clk;

  // Value compare, counted
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Present one byte; return where its answer has settled
  task put(input logic [7:0] b);
    i_byte_valid = 1'b1;
    i_byte = b;
    @(posedge i_sys_clk);
    #2;
  endtask : put

  // Feed opcode, optional mode byte, then trailing bytes; check the answer
  task dec(input logic [7:0] b0, input logic m, input logic [7:0] b1,
           input opdec_pkg::opdec_op_t op, input logic [2:0] tl);
    put(b0);
    if (m) begin
      cmp(o_done, 1'b0);
      put(b1);
    end
    cmp(o_done, 1'b1);
    cmp({2'b00, o_op}, {2'b00, op});
    cmp({5'h00, o_trail_len}, {5'h00, tl});
    if (m) begin
      cmp({o_mod, o_reg, o_rm}, b1);
      cmp(o_operand_is_reg, b1[7:6] == opdec_pkg::MOD_REG);
    end
    for (int k = 0; k < tl; k++) begin
      put(8'h55);
      cmp({o_done, o_illegal}, 8'h00);
    end
  endtask : dec

  // Byte pair outside the map must flag illegal
  task ill(input logic [7:0] b0, input logic [7:0] b1);
    put(b0);
    put(b1);
    cmp({o_done, o_illegal}, 8'h01);
  endtask : ill

  // Single-byte opcodes
  task t_single;
    for (int i = 0; i < 6; i++) begin
      dec(sb_opc[i], 1'b0, 8'h00, sb_op[i], 3'h0);
    end
    $display("test single done");
  endtask : t_single

  // Multiply, divide, mask compare and invert group
  task t_grp;
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 6; i++) begin
        dec({opdec_pkg::OP7_GRP_F6, w[0]}, 1'b1, {w[0], w[0], f6_ext[i], 3'h1}, f6_op[i],
            (i == 0) ? 3'(w + 1) : 3'h0);
        cmp(o_word, w[0]);
      end
    end
    ill(8'hf7, 8'hd8);
    $display("test grp done");
  endtask : t_grp

  // Two-byte adjusts and a bad base byte
  task t_adjust;
    put(8'hd4);
    cmp(o_done, 1'b0);
    put(8'h0a);
    cmp({o_done, 1'b0, o_op}, {1'b1, 1'b0, opdec_pkg::OPD_ASCII_PRODUCT_ADJUST});
    put(8'hd5);
    put(8'h0a);
    cmp({o_done, 1'b0, o_op}, {1'b1, 1'b0, opdec_pkg::OPD_ASCII_QUOTIENT_ADJUST});
    ill(8'hd4, 8'h0b);
    $display("test adjust done");
  endtask : t_adjust

  // Shift and rotate: every extension, every v and w
  task t_shift;
    for (int vw = 0; vw < 4; vw++) begin
      for (int e = 0; e < 8; e++) begin
        if (e == 6) ill({opdec_pkg::OP6_SHIFT, 2'(vw)}, 8'hf3);
        else begin
          dec({opdec_pkg::OP6_SHIFT, 2'(vw)}, 1'b1, {2'h3, 3'(e), 3'h3}, sh_op[e],
              3'h0);
          cmp({o_count_from_reg, o_word}, 8'(vw));
        end
      end
    end
    $display("test shift done");
  endtask : t_shift

  // Or, exclusive or, flags-only and forms
  task t_logic;
    for (int dw = 0; dw < 4; dw++) begin
      dec({opdec_pkg::OP6_OR_RM, 2'(dw)}, 1'b1, 8'hc1, opdec_pkg::OPD_OR_RM, 3'h0);
      dec({opdec_pkg::OP6_XOR_RM, 2'(dw)}, 1'b1, 8'h1a, opdec_pkg::OPD_XOR_RM, 3'h0);
    end
    for (int w = 0; w < 2; w++) begin
      dec({opdec_pkg::OP7_TEST_RM, w[0]}, 1'b1, 8'hd7, opdec_pkg::OPD_MASK_COMPARE_RM,
          3'h0);
      dec({opdec_pkg::OP7_TEST_ACC, w[0]}, 1'b0, 8'h00, opdec_pkg::OPD_MASK_COMPARE_ACC,
          3'(w + 1));
    end
    $display("test logic done");
  endtask : t_logic

  // String primitives without and with each repeat prefix
  task t_string;
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 5; i++) begin
        if (p > 0) begin
          put({opdec_pkg::OP7_LOOP_PREFIX, p == 2});
          cmp({o_done, o_illegal}, 8'h00);
        end
        dec({st_opc[i], i[0]}, 1'b0, 8'h00, st_op[i], 3'h0);
        cmp({o_repeat, o_word}, {p > 0, i[0]});
        cmp(o_repeat_zf, p == 2);
      end
    end
    $display("test string done");
  endtask : t_string

  // Calls, jumps and immediate return, with swallowed trailing bytes
  task t_branch;
    for (int i = 0; i < 6; i++) begin
      dec(br_opc[i], 1'b0, 8'h00, br_op[i], br_len[i]);
    end
    for (int e = 2; e < 6; e++) begin
      dec(opdec_pkg::OP_GRP_FF, 1'b1, {2'h3, 3'(e), 3'h2}, ff_op[e - 2],
          3'h0);
    end
    ill(8'hff, 8'hc0);
    $display("test branch done");
  endtask : t_branch

  // Reset mid-instruction clears outputs and drops the held opcode
  task t_reset;
    put(8'hcb);
    put(8'hd4);
    i_rst_n = 1'b0;
    @(posedge i_sys_clk);
    #2;
    cmp({2'b00, o_op}, {2'b00, opdec_pkg::OPD_NONE});
    cmp({o_done, o_word, o_illegal, 2'b00, o_trail_len}, 8'h00);
    i_rst_n = 1'b1;
    dec(8'h3f, 1'b0, 8'h00, opdec_pkg::OPD_ASCII_SUB_ADJUST, 3'h0);
    $display("test reset done");
  endtask : t_reset

  // Verdict and end of run
  task end_sim;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #2 i_rst_n = 1'b1;
    t_single();
    t_grp();
    t_adjust();
    t_shift();
    t_logic();
    t_string();
    t_branch();
    t_reset();
    end_sim();
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #500000;
    num_errors++;
    end_sim();
  end
endmodule : test_opcode_decode_arith_logic_string_branch
